// >>> rtl/biexec_core.sv
// Four-phase executor for AND, bit clear, bit toggle and bit test skip
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - AND working register with addressed file byte; opcode 0000 101d plus address.
// - Destination bit zero writes working register; one writes the file byte.
// - Bit clear forces selected bit of file byte to zero; flags unchanged.
// - Bit test skips next instruction if selected bit set; address 0 to 127.
// - Taken skip discards fetched word and runs a no-operation cycle instead.
module biexec_core (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Instruction from the fetch path
	input  wire logic [15:0] instr_word,
	input  wire logic        instr_valid,
	output logic             fetch_ack,
	output logic             discarding,
	output logic             unknown_op,
	// Core state
	output logic      [7:0]  working_register,
	output logic             zero_flag,
	output logic      [1:0]  phase_id,
	// File preload and observation
	input  wire logic        ld_en,
	input  wire logic [7:0]  ld_addr,
	input  wire logic [7:0]  ld_data,
	input  wire logic [7:0]  peek_addr,
	output logic      [7:0]  peek_data
);

	typedef struct packed {
		biexec_pkg::biexec_phase_e phase;
		biexec_pkg::biexec_op_e    op;
		logic                      dst_file;
		logic [2:0]                bit_sel;
		logic [7:0]                addr;
		logic [7:0]                operand;
		logic [7:0]                result;
		logic [7:0]                work_reg;
		logic                      zero;
		logic                      skip_pend;
		logic                      discarding;
		logic                      fetch_ack;
		logic                      illegal;
	} biexec_core_s;

	biexec_core_s s;
	biexec_core_s next_s;

	logic       file_rd;
	logic       file_we;
	logic [7:0] file_rdata;
	logic [7:0] bit_mask;

	// File access strobes follow the phase
	assign file_rd  = (s.phase == biexec_pkg::PH_READ);
	assign file_we  = (s.phase == biexec_pkg::PH_WRITE) &&
		((s.op == biexec_pkg::OP_AND && s.dst_file) ||
		 s.op == biexec_pkg::OP_BCLR || s.op == biexec_pkg::OP_BTOG);
	assign bit_mask = 8'h01 << s.bit_sel;

	biexec_file_ram biexec_file_ram_inst (
		.clk       (clk),
		.rst_n     (rst_n),
		.rd_en     (file_rd),
		.rd_addr   (s.addr),
		.rd_data   (file_rdata),
		.wr_en     (file_we),
		.wr_addr   (s.addr),
		.wr_data   (s.result),
		.ld_en     (ld_en),
		.ld_addr   (ld_addr),
		.ld_data   (ld_data),
		.peek_addr (peek_addr),
		.peek_data (peek_data)
	);

	// Phase sequencer, decoder and data path
	always_comb begin
		next_s = s;
		next_s.fetch_ack = 1'b0;
		unique case (s.phase)
			biexec_pkg::PH_DECODE: begin
				next_s.phase      = biexec_pkg::PH_READ;
				next_s.op         = biexec_pkg::OP_NOP;
				next_s.illegal    = 1'b0;
				next_s.discarding = s.skip_pend;
				next_s.skip_pend  = 1'b0;
				next_s.dst_file   = instr_word[biexec_pkg::DST_POS];
				next_s.bit_sel    = instr_word[biexec_pkg::BIT_LSB +: biexec_pkg::BIT_W];
				next_s.addr       = instr_word[biexec_pkg::ADDR_LSB +: biexec_pkg::ADDR_W];
				if (instr_valid) begin
					next_s.fetch_ack = 1'b1;
				end
				if (instr_valid && !s.skip_pend) begin
					if (instr_word[15:9] == biexec_pkg::OPC_AND_WORKING) begin
						next_s.op = biexec_pkg::OP_AND;
					end else if (instr_word[15:11] == biexec_pkg::OPC_BIT_CLEAR) begin
						next_s.op = biexec_pkg::OP_BCLR;
					end else if (instr_word[15:11] == biexec_pkg::OPC_BIT_TEST_SET) begin
						next_s.op   = biexec_pkg::OP_BTST;
						next_s.addr = instr_word[7:0] & biexec_pkg::TEST_ADDR_MASK;
					end else if (instr_word[15:11] == biexec_pkg::OPC_BIT_TOGGLE) begin
						next_s.op = biexec_pkg::OP_BTOG;
					end else begin
						next_s.illegal = 1'b1;
					end
				end
			end
			biexec_pkg::PH_READ: begin
				next_s.phase = biexec_pkg::PH_PROCESS;
			end
			biexec_pkg::PH_PROCESS: begin
				next_s.phase   = biexec_pkg::PH_WRITE;
				next_s.operand = file_rdata;
				next_s.result  = file_rdata;
				unique case (s.op)
					biexec_pkg::OP_AND:  next_s.result = s.work_reg & file_rdata;
					biexec_pkg::OP_BCLR: next_s.result = file_rdata & ~bit_mask;
					biexec_pkg::OP_BTOG: next_s.result = file_rdata ^ bit_mask;
					biexec_pkg::OP_BTST: begin
						next_s.skip_pend = |(file_rdata & bit_mask);
					end
					biexec_pkg::OP_NOP:  next_s.result = file_rdata;
				endcase
			end
			biexec_pkg::PH_WRITE: begin
				next_s.phase = biexec_pkg::PH_DECODE;
				if (s.op == biexec_pkg::OP_AND) begin
					next_s.zero = (s.result == 8'h00);
					if (!s.dst_file) begin
						next_s.work_reg = s.result;
					end
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign fetch_ack        = s.fetch_ack;
	assign discarding       = s.discarding;
	assign unknown_op       = s.illegal;
	assign working_register = s.work_reg;
	assign zero_flag        = s.zero;
	assign phase_id         = s.phase;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// AND into the working register
	and_to_work_a: assert property (
		(s.phase == biexec_pkg::PH_WRITE && s.op == biexec_pkg::OP_AND && !s.dst_file)
		|=> s.work_reg == ($past(s.work_reg) & $past(s.operand))
	) else $error("AND result not in working register");

	// AND into the file leaves the working register alone
	and_to_file_a: assert property (
		(s.phase == biexec_pkg::PH_WRITE && s.op == biexec_pkg::OP_AND && s.dst_file)
		|-> file_we && s.result == (s.work_reg & s.operand) ##1 s.work_reg == $past(s.work_reg)
	) else $error("AND to file misdirected");

	// Bit clear touches one bit and no flag
	bit_clear_a: assert property (
		(s.phase == biexec_pkg::PH_WRITE && s.op == biexec_pkg::OP_BCLR)
		|-> file_we && s.result == (s.operand & ~bit_mask) ##1 s.zero == $past(s.zero)
	) else $error("Bit clear wrong");

	// Test reaches only the lower half and arms the skip
	test_skip_a: assert property (
		(s.phase == biexec_pkg::PH_PROCESS && s.op == biexec_pkg::OP_BTST)
		|-> !s.addr[7] ##1 s.skip_pend == |(s.operand & bit_mask)
	) else $error("Bit test decision wrong");

	// Skipped slot runs as a no-operation for a whole cycle
	skip_nop_a: assert property (
		(s.phase == biexec_pkg::PH_WRITE && s.skip_pend)
		|=> ##1 (s.discarding && s.op == biexec_pkg::OP_NOP && !file_we)[*4]
	) else $error("Skipped instruction executed");

	// Toggle flips exactly the selected bit
	bit_toggle_a: assert property (
		(s.phase == biexec_pkg::PH_WRITE && s.op == biexec_pkg::OP_BTOG)
		|-> file_we && (s.result ^ s.operand) == bit_mask ##1 s.zero == $past(s.zero)
	) else $error("Bit toggle wrong");

	// Four phases in order
	phase_order_a: assert property (
		(s.phase == biexec_pkg::PH_DECODE) |=> s.phase == biexec_pkg::PH_READ
		##1 s.phase == biexec_pkg::PH_PROCESS ##1 s.phase == biexec_pkg::PH_WRITE
		##1 s.phase == biexec_pkg::PH_DECODE
	) else $error("Phase order broken");

	// Zero flag follows the AND result only
	zero_flag_a: assert property (
		(s.phase == biexec_pkg::PH_WRITE && s.op != biexec_pkg::OP_AND)
		|=> s.zero == $past(s.zero)
	) else $error("Zero flag changed by non-AND");

	// Zero flag mirrors an all-zero AND result
	and_zero_a: assert property (
		(s.phase == biexec_pkg::PH_WRITE && s.op == biexec_pkg::OP_AND)
		|=> s.zero == ($past(s.result) == 8'h00)
	) else $error("Zero flag does not match AND result");

	// A word offered at decode is acknowledged next cycle
	fetch_ack_a: assert property (
		(s.phase == biexec_pkg::PH_DECODE && instr_valid) |=> s.fetch_ack
	) else $error("Fetched word not acknowledged");

	// Word in a skipped slot is taken but turned into a no-operation
	discard_ack_a: assert property (
		(s.phase == biexec_pkg::PH_DECODE && s.skip_pend && instr_valid)
		|=> s.fetch_ack && s.discarding && s.op == biexec_pkg::OP_NOP
	) else $error("Skipped word not discarded");

	// Unknown word writes nothing and keeps the flags
	unknown_quiet_a: assert property (
		(s.phase == biexec_pkg::PH_WRITE && s.illegal)
		|-> !file_we ##1 s.zero == $past(s.zero) && s.work_reg == $past(s.work_reg)
	) else $error("Unknown word had an effect");

endmodule
`default_nettype wire

// >>> rtl/biexec_pkg.sv
// Constants and types shared by the bit and logic instruction executor
package biexec_pkg;

	// Data memory geometry
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 8;
	localparam int RAM_WORDS = 256;

	// Instruction word layout
	localparam int INSTR_W  = 16;
	localparam int DST_POS  = 8;
	localparam int BIT_LSB  = 8;
	localparam int BIT_W    = 3;
	localparam int ADDR_LSB = 0;

	// Opcode patterns and the top bits they are compared against
	localparam logic [6:0] OPC_AND_WORKING  = 7'h05;   // 0000 101d
	localparam logic [4:0] OPC_BIT_CLEAR    = 5'h11;   // 1000 1bbb
	localparam logic [4:0] OPC_BIT_TEST_SET = 5'h12;   // 1001 0bbb
	localparam logic [4:0] OPC_BIT_TOGGLE   = 5'h07;   // 0011 1bbb

	// Test instruction can only reach the lower half of the file
	localparam logic [7:0] TEST_ADDR_MASK = 8'h7f;

	// Reset values
	localparam logic [7:0] WORK_REG_RESET = 8'h00;

	// Four phases of one instruction cycle
	typedef enum logic [1:0] {
		PH_DECODE,
		PH_READ,
		PH_PROCESS,
		PH_WRITE
	} biexec_phase_e;

	// Operations carried by the executor
	typedef enum logic [2:0] {
		OP_NOP,
		OP_AND,
		OP_BCLR,
		OP_BTST,
		OP_BTOG
	} biexec_op_e;

endpackage

// >>> rtl/biexec_file_ram.sv
// Data memory file with registered read and peek ports
`timescale 1ns/1ps
`default_nettype none

module biexec_file_ram (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Core read port
	input  wire logic       rd_en,
	input  wire logic [7:0] rd_addr,
	output logic      [7:0] rd_data,
	// Core write port, wins over the load port
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_addr,
	input  wire logic [7:0] wr_data,
	// Side port for preloading and observing the file
	input  wire logic       ld_en,
	input  wire logic [7:0] ld_addr,
	input  wire logic [7:0] ld_data,
	input  wire logic [7:0] peek_addr,
	output logic      [7:0] peek_data
);

	typedef struct packed {
		logic [biexec_pkg::RAM_WORDS-1:0][biexec_pkg::DATA_W-1:0] mem;
		logic [biexec_pkg::DATA_W-1:0]                          rd_data;
		logic [biexec_pkg::DATA_W-1:0]                          peek_data;
	} biexec_ram_s;

	biexec_ram_s s;
	biexec_ram_s next_s;

	// Writes and registered reads
	always_comb begin
		next_s = s;
		if (rd_en) begin
			next_s.rd_data = s.mem[rd_addr];
		end
		next_s.peek_data = s.mem[peek_addr];
		if (wr_en) begin
			next_s.mem[wr_addr] = wr_data;
		end else if (ld_en) begin
			next_s.mem[ld_addr] = ld_data;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data   = s.rd_data;
	assign peek_data = s.peek_data;

endmodule
`default_nettype wire

// >>> verif/bit_and_logic_instruction_exec_tb_top.sv
// Self-checking bench for the four-phase bit and logic executor
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) checks_done++; if ((got) !== (ex)) begin fails++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end

module bit_and_logic_instruction_exec_tb_top;
	// Bench signals
	logic        clk;
	logic        rst_n;
	logic [15:0] instr_word;
	logic        instr_valid;
	logic        fetch_ack;
	logic        discarding;
	logic        unknown_op;
	logic [7:0]  working_register;
	logic        zero_flag;
	logic [1:0]  phase_id;
	logic        ld_en;
	logic [7:0]  ld_addr;
	logic [7:0]  ld_data;
	logic [7:0]  peek_addr;
	logic [7:0]  peek_data;
	int          fails;
	int          checks_done;
	logic        dis;
	logic        unk;
	logic [7:0]  got;

	biexec_core biexec_core_inst (
		.clk(clk), .rst_n(rst_n), .instr_word(instr_word), .instr_valid(instr_valid),
		.fetch_ack(fetch_ack), .discarding(discarding), .unknown_op(unknown_op),
		.working_register(working_register), .zero_flag(zero_flag), .phase_id(phase_id),
		.ld_en(ld_en), .ld_addr(ld_addr), .ld_data(ld_data),
		.peek_addr(peek_addr), .peek_data(peek_data)
	);

	// Clock at 25 MHz
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Verdict and end of run
	task automatic end_sim();
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Preload one file byte while no instruction writes
	task automatic load(input logic [7:0] a, input logic [7:0] d);
		ld_en = 1'b1;
		ld_addr = a;
		ld_data = d;
		@(posedge clk); #1;
		ld_en = 1'b0;
	endtask

	// Read one file byte through the registered peek port
	task automatic peek(input logic [7:0] a, output logic [7:0] d);
		peek_addr = a;
		repeat (2) begin @(posedge clk); #1; end
		d = peek_data;
	endtask

	// Present one word at a decode phase and run its four phases
	task automatic issue(input logic [15:0] w, output logic ds, output logic uk);
		int n;
		n = 0;
		while (phase_id !== 2'h0 && n < 8) begin @(posedge clk); #1; n++; end
		instr_word = w;
		instr_valid = 1'b1;
		@(posedge clk); #1;
		instr_valid = 1'b0;
		`CHK("fetch_ack", 1'b1, fetch_ack)
		`CHK("phase_id", 2'h1, phase_id)
		ds = discarding;
		uk = unknown_op;
		repeat (3) begin @(posedge clk); #1; end
	endtask

	// AND to file and to working register, zero flag set
	task automatic t_and();
		load(8'h10, 8'hc2);
		`CHK("zero_rst", 1'b0, zero_flag)
		issue(16'h0b10, dis, unk);
		peek(8'h10, got);
		`CHK("and_file", 8'h00, got)
		`CHK("zero_and", 1'b1, zero_flag)
		load(8'h11, 8'h5a);
		issue(16'h0a11, dis, unk);
		`CHK("and_working_register", 8'h00, working_register)
		peek(8'h11, got);
		`CHK("and_keep", 8'h5a, got)
	endtask

	// Bit clear and toggle leave the zero flag alone
	task automatic t_bits();
		load(8'h20, 8'hc7);
		issue(16'h8f20, dis, unk);
		peek(8'h20, got);
		`CHK("bclr", 8'h47, got)
		`CHK("bclr_z", 1'b1, zero_flag)
		`CHK("bclr_unk", 1'b0, unk)
		load(8'h30, 8'h75);
		issue(16'h3c30, dis, unk);
		peek(8'h30, got);
		`CHK("btog", 8'h65, got)
		`CHK("btog_z", 1'b1, zero_flag)
	endtask

	// Skip taken on a set bit, high address bit ignored; not taken on clear bit
	task automatic t_skip();
		load(8'h05, 8'h02);
		issue(16'h9185, dis, unk);
		issue(16'h3c30, dis, unk);
		`CHK("skip_dis", 1'b1, dis)
		peek(8'h30, got);
		`CHK("skip_nowr", 8'h65, got)
		issue(16'h9205, dis, unk);
		issue(16'h3c30, dis, unk);
		`CHK("noskip_dis", 1'b0, dis)
		peek(8'h30, got);
		`CHK("noskip_wr", 8'h75, got)
		issue(16'hffff, dis, unk);
		`CHK("unknown", 1'b1, unk)
		`CHK("unk_z", 1'b1, zero_flag)
		peek(8'hff, got);
		`CHK("unk_nowr", 8'h00, got)
	endtask

	// Reset in mid-run clears flags, phase and file; first word after it runs
	task automatic t_reset();
		rst_n = 1'b0;
		repeat (2) begin @(posedge clk); #1; end
		`CHK("rst_zero", 1'b0, zero_flag)
		`CHK("rst_unk", 1'b0, unknown_op)
		`CHK("rst_phase", 2'h0, phase_id)
		rst_n = 1'b1;
		issue(16'h3a30, dis, unk);
		peek(8'h30, got);
		`CHK("rst_btog", 8'h04, got)
		`CHK("rst_btog_z", 1'b0, zero_flag)
	endtask

	// Watchdog
	initial begin
		#(40 * 2000);
		fails++;
		end_sim();
	end

	// Main sequence
	initial begin
		rst_n = 1'b0;
		instr_word = 16'h0000;
		instr_valid = 1'b0;
		ld_en = 1'b0;
		ld_addr = 8'h00;
		ld_data = 8'h00;
		peek_addr = 8'h00;
		fails = 0;
		checks_done = 0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		t_and();
		t_bits();
		t_skip();
		t_reset();
		end_sim();
	end
endmodule

`default_nettype wire
